// *** hw/ddc_out_map.svh ***
// offsets, field positions, reset values and counts of the downconverter output port
`ifndef DDC_OUT_MAP_SVH
`define DDC_OUT_MAP_SVH

// host write locations
`define CTL_DIRECT_SEL   3'h0
`define CTL_SER_DIV      3'h1
`define CTL_SER_ORDER_A  3'h2
`define CTL_SER_ORDER_B  3'h3
`define CTL_MODE         3'h4
`define CTL_COUNT        3'h5

// host read locations
`define RD_STORE_COUNT   3'h0
`define RD_STATUS        3'h1
`define RD_STORE_POP     3'h2

// mode bits
`define MODE_BUF_EN      0
`define MODE_SER_EN      1
`define MODE_DIRECT_EN   2

// status bits
`define STAT_OVERFLOW    0
`define STAT_NOT_EMPTY   1
`define STAT_FULL        2

// serial order fields
`define ORDER_W0_LSB     0
`define ORDER_W1_LSB     3

// reset values
`define RST_DIRECT_SEL   8'h00
`define RST_SER_DIV      8'h03
`define RST_SER_ORDER_A  8'h08
`define RST_SER_ORDER_B  8'h1a
`define RST_MODE         8'h07

// direct port sources
`define DSEL_IQ          2'h0
`define DSEL_MAG_PHASE   2'h1
`define DSEL_FREQ_MAG    2'h2

// item codes, shared by the serial order and, up to ITEM_FREQ, the buffer item select
`define ITEM_I           3'h0
`define ITEM_Q           3'h1
`define ITEM_MAG         3'h2
`define ITEM_PHASE       3'h3
`define ITEM_FREQ        3'h4
`define ITEM_TE          3'h5
`define ITEM_AGC         3'h6

// counts
`define IRQ_LOW_CYCLES   4'h8
`define STORE_DEPTH      3'h7
`define SER_LAST_BIT     4'hf

`endif

// *** hw/ddc_out_pkg.sv ***
// types of the downconverter output port
package ddc_out_pkg;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
    logic [15:0] mag;
    logic [15:0] phase;
    logic [15:0] freq;
    logic [15:0] te;
    logic [15:0] agc;
  } sample_s;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
    logic [15:0] mag;
    logic [15:0] phase;
    logic [15:0] freq;
  } data_set_s;

  typedef logic [2:0] ptr_t;

  typedef enum logic [0:0] {SER_IDLE, SER_SHIFT} ser_state_e;

  typedef struct packed {
    sample_s [1:0] slot;
    logic          rd;
    logic          wr;
    logic [1:0]    cnt;
  } skid_state_s;

  typedef struct packed {
    data_set_s [6:0] mem;
    ptr_t            wr_ptr;
    ptr_t            rd_ptr;
    logic [2:0]      count;
  } store_state_s;

  typedef struct packed {
    logic            wr_s1;
    logic            wr_s2;
    logic            wr_d;
    logic            rd_s1;
    logic            rd_s2;
    logic            rd_d;
    logic [2:0]      addr_s1;
    logic [2:0]      addr_s2;
    logic [7:0]      data_s1;
    logic [7:0]      data_s2;
    logic [2:0]      item_sel_s1;
    logic [2:0]      item_sel_s2;
    logic [3:0]      oe_n_s1;
    logic [3:0]      oe_n_s2;
    logic            ser_tri_s1;
    logic            ser_tri_s2;
    logic [4:0][7:0] ctl;
    logic [7:0]      rd_data;
    logic            rd_active;
    logic            overflow;
    logic [15:0]     port_a;
    logic [15:0]     port_b;
    logic [7:0]      low_a;
    logic [7:0]      low_b;
    logic            strobe_n;
    logic            was_empty;
    logic [3:0]      irq_cnt;
    logic            irq_n;
    ser_state_e      ser_state;
    logic [7:0]      div_cnt;
    logic            ser_clk;
    logic            ser_sync;
    logic [3:0]      bit_cnt;
    logic            word_idx;
    logic [15:0]     shift_a;
    logic [15:0]     shift_b;
    logic [15:0]     next_a;
    logic [15:0]     next_b;
  } port_state_s;

endpackage

// *** hw/two_entry_buffer.sv ***
// two-entry sample buffer with valid and ready on both sides
`timescale 1ns/1ps
module two_entry_buffer
  import ddc_out_pkg::*;
(
  // clock and reset
  input  wire logic    core_clk,
  input  wire logic    rst,
  // filling side
  input  wire logic    in_valid,
  output logic         in_ready,
  input  sample_s      in_data,
  // draining side
  output logic         out_valid,
  input  wire logic    out_ready,
  output sample_s      out_data
);

  skid_state_s st_ff;
  skid_state_s nxt_st;
  logic        push;
  logic        pop;

  assign in_ready  = (st_ff.cnt != 2'h2);
  assign out_valid = (st_ff.cnt != 2'h0);
  assign out_data  = st_ff.slot[st_ff.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.slot[st_ff.wr] = in_data;
      nxt_st.wr             = ~st_ff.wr;
    end
    if (pop) begin
      nxt_st.rd = ~st_ff.rd;
    end
    // both at once keeps the count
    nxt_st.cnt = 2'(st_ff.cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule // two_entry_buffer

// *** hw/data_set_store.sv ***
// queue of complete data sets for the buffered output port
`timescale 1ns/1ps
`include "ddc_out_map.svh"
module data_set_store
  import ddc_out_pkg::*;
(
  // clock and reset
  input  wire logic    core_clk,
  input  wire logic    rst,
  // write side
  input  wire logic    push,
  input  data_set_s    push_data,
  // read side
  input  wire logic    pop,
  output data_set_s    head,
  // status
  output logic         empty,
  output logic         full,
  output logic [2:0]   count
);

  store_state_s st_ff;
  store_state_s nxt_st;
  logic         do_push;
  logic         do_pop;

  assign count   = st_ff.count;
  assign empty   = (st_ff.count == 3'h0);
  assign full    = (st_ff.count == `STORE_DEPTH);
  assign head    = st_ff.mem[st_ff.rd_ptr];
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;

  function automatic ptr_t wrap_inc(input ptr_t p);
    return (p == 3'(`STORE_DEPTH - 3'h1)) ? 3'h0 : 3'(p + 3'h1);
  endfunction

  always_comb begin
    nxt_st = st_ff;
    if (do_push) begin
      nxt_st.mem[st_ff.wr_ptr] = push_data;
      nxt_st.wr_ptr            = wrap_inc(st_ff.wr_ptr);
    end
    if (do_pop) begin
      nxt_st.rd_ptr = wrap_inc(st_ff.rd_ptr);
    end
    nxt_st.count = 3'(st_ff.count + {2'h0, do_push} - {2'h0, do_pop});
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule // data_set_store

// *** hw/downconverter_output_host_port.sv ***
// output pins and host strobe logic of the downconverter back end
`timescale 1ns/1ps
`include "ddc_out_map.svh"
module downconverter_output_host_port
  import ddc_out_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // samples from the filter chain
  input  wire logic         sample_valid,
  output logic              sample_ready,
  input  sample_s           sample_data,
  // parallel output buses
  output logic [15:0]       parallel_port_a_out,
  output logic [15:0]       parallel_port_a_oe,
  output logic [15:0]       parallel_port_b_out,
  output logic [15:0]       parallel_port_b_oe,
  input  wire logic         port_a_high_byte_oe_n,
  input  wire logic         port_a_low_byte_oe_n,
  input  wire logic         port_b_high_byte_oe_n,
  input  wire logic         port_b_low_byte_oe_n,
  output logic              new_sample_strobe_n,
  // buffered output
  input  wire logic [2:0]   buffer_item_select,
  output logic              buffer_ready_irq_n,
  // serial output
  output logic              serial_out_a,
  output logic              serial_out_b,
  output logic              serial_bit_clock,
  output logic              serial_frame_strobe,
  output logic              serial_oe,
  input  wire logic         serial_tristate_ctl,
  // host processor strobes
  input  wire logic         host_write_strobe,
  input  wire logic         host_read_strobe,
  input  wire logic [2:0]   host_addr_bus,
  input  wire logic [7:0]   host_data_in,
  output logic [7:0]        host_data_out,
  output logic              host_data_oe
);

  port_state_s st_ff;
  port_state_s nxt_st;

  sample_s     buf_data;
  logic        buf_valid;
  logic        buf_ready;
  logic        accept;
  data_set_s   head_set;
  logic        store_empty;
  logic        store_full;
  logic [2:0]  store_count;
  logic        store_push;
  logic        store_pop;
  logic        wr_rise;
  logic        rd_fall;
  logic        rd_rise;
  logic [3:0]  lane_oe;
  logic        ser_en;
  logic        buf_en;
  logic        direct_en;
  logic [15:0] item_word;

  // absorbs a sample while the serializer is busy so none is dropped
  two_entry_buffer u_in_buffer (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (sample_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  data_set_store u_store (
    .core_clk  (core_clk),
    .rst       (rst),
    .push      (store_push),
    .push_data ({buf_data.i, buf_data.q, buf_data.mag, buf_data.phase, buf_data.freq}),
    .pop       (store_pop),
    .head      (head_set),
    .empty     (store_empty),
    .full      (store_full),
    .count     (store_count)
  );

  function automatic logic [15:0] pick_item(input sample_s s, input logic [2:0] code);
    unique case (code)
      `ITEM_I:     return s.i;
      `ITEM_Q:     return s.q;
      `ITEM_MAG:   return s.mag;
      `ITEM_PHASE: return s.phase;
      `ITEM_FREQ:  return s.freq;
      `ITEM_TE:    return s.te;
      `ITEM_AGC:   return s.agc;
      default:     return 16'h0000;
    endcase
  endfunction

  assign ser_en     = st_ff.ctl[`CTL_MODE][`MODE_SER_EN];
  assign buf_en     = st_ff.ctl[`CTL_MODE][`MODE_BUF_EN];
  assign direct_en  = st_ff.ctl[`CTL_MODE][`MODE_DIRECT_EN];
  // serializer is the only stage that can stall the buffer
  assign buf_ready  = ~ser_en | (st_ff.ser_state == SER_IDLE);
  assign accept     = buf_valid & buf_ready;
  assign store_push = accept & buf_en;
  // edges are taken from the second synchronizer stage only
  assign wr_rise    = st_ff.wr_s2 & ~st_ff.wr_d;
  assign rd_fall    = ~st_ff.rd_s2 & st_ff.rd_d;
  assign rd_rise    = st_ff.rd_s2 & ~st_ff.rd_d;
  assign store_pop  = rd_fall & (st_ff.addr_s2 == `RD_STORE_POP);

  // head item chosen by the host select; unused codes read zero
  always_comb begin
    unique case (st_ff.item_sel_s2)
      `ITEM_I:     item_word = head_set.i;
      `ITEM_Q:     item_word = head_set.q;
      `ITEM_MAG:   item_word = head_set.mag;
      `ITEM_PHASE: item_word = head_set.phase;
      `ITEM_FREQ:  item_word = head_set.freq;
      default:     item_word = 16'h0000;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;

    // pin synchronizers
    nxt_st.wr_s1       = host_write_strobe;
    nxt_st.wr_s2       = st_ff.wr_s1;
    nxt_st.wr_d        = st_ff.wr_s2;
    nxt_st.rd_s1       = host_read_strobe;
    nxt_st.rd_s2       = st_ff.rd_s1;
    nxt_st.rd_d        = st_ff.rd_s2;
    nxt_st.addr_s1     = host_addr_bus;
    nxt_st.addr_s2     = st_ff.addr_s1;
    nxt_st.data_s1     = host_data_in;
    nxt_st.data_s2     = st_ff.data_s1;
    nxt_st.item_sel_s1 = buffer_item_select;
    nxt_st.item_sel_s2 = st_ff.item_sel_s1;
    nxt_st.oe_n_s1     = {port_a_high_byte_oe_n, port_a_low_byte_oe_n,
                          port_b_high_byte_oe_n, port_b_low_byte_oe_n};
    nxt_st.oe_n_s2     = st_ff.oe_n_s1;
    nxt_st.ser_tri_s1  = serial_tristate_ctl;
    nxt_st.ser_tri_s2  = st_ff.ser_tri_s1;

    // host write into the control locations
    if (wr_rise && (st_ff.addr_s2 < `CTL_COUNT)) begin
      nxt_st.ctl[st_ff.addr_s2] = st_ff.data_s2;
    end

    // host read: byte latched at the falling edge, driven until the rise
    if (rd_fall) begin
      nxt_st.rd_active = 1'b1;
      unique case (st_ff.addr_s2)
        `RD_STORE_COUNT: nxt_st.rd_data = {5'h00, store_count};
        `RD_STATUS:      nxt_st.rd_data = {5'h00, store_full, ~store_empty, st_ff.overflow};
        `RD_STORE_POP:   nxt_st.rd_data = {5'h00, store_count};
        default:         nxt_st.rd_data = st_ff.ctl[st_ff.addr_s2[1:0]];
      endcase
    end else if (rd_rise) begin
      nxt_st.rd_active = 1'b0;
    end

    // overflow: cleared by a status read, a new drop wins over the clear
    if (rd_fall && (st_ff.addr_s2 == `RD_STATUS)) begin
      nxt_st.overflow = 1'b0;
    end
    if (store_push && store_full) begin
      nxt_st.overflow = 1'b1;
    end

    // direct port: new value and strobe in the same cycle, else held
    nxt_st.strobe_n = 1'b1;
    if (accept && direct_en) begin
      nxt_st.strobe_n = 1'b0;
      unique case (st_ff.ctl[`CTL_DIRECT_SEL][1:0])
        `DSEL_MAG_PHASE: begin
          nxt_st.port_a = buf_data.mag;
          nxt_st.port_b = buf_data.phase;
        end
        `DSEL_FREQ_MAG: begin
          nxt_st.port_a = buf_data.freq;
          nxt_st.port_b = buf_data.mag;
        end
        default: begin
          nxt_st.port_a = buf_data.i;
          nxt_st.port_b = buf_data.q;
        end
      endcase
    end

    // low bytes carry the buffered word when that mode is on
    if (buf_en) begin
      nxt_st.low_a = item_word[15:8];
      nxt_st.low_b = item_word[7:0];
    end else begin
      nxt_st.low_a = nxt_st.port_a[7:0];
      nxt_st.low_b = nxt_st.port_b[7:0];
    end

    // interrupt pulse when the store turns from empty to readable
    nxt_st.was_empty = store_empty;
    if (st_ff.was_empty && !store_empty) begin
      nxt_st.irq_cnt = `IRQ_LOW_CYCLES;
    end else if (st_ff.irq_cnt != 4'h0) begin
      nxt_st.irq_cnt = 4'(st_ff.irq_cnt - 4'h1);
    end
    nxt_st.irq_n = (nxt_st.irq_cnt == 4'h0);

    // serializer: two words per sample, a frame strobe with the first bit of each, msb first, data moves on falling edges
    unique case (st_ff.ser_state)
      SER_IDLE: begin
        nxt_st.ser_clk  = 1'b0;
        nxt_st.ser_sync = 1'b0;
        nxt_st.div_cnt  = 8'h00;
        if (accept && ser_en) begin
          nxt_st.ser_state = SER_SHIFT;
          nxt_st.shift_a   = pick_item(buf_data, st_ff.ctl[`CTL_SER_ORDER_A][2:0]);
          nxt_st.next_a    = pick_item(buf_data, st_ff.ctl[`CTL_SER_ORDER_A][5:3]);
          nxt_st.shift_b   = pick_item(buf_data, st_ff.ctl[`CTL_SER_ORDER_B][2:0]);
          nxt_st.next_b    = pick_item(buf_data, st_ff.ctl[`CTL_SER_ORDER_B][5:3]);
          nxt_st.ser_sync  = 1'b1;
          nxt_st.bit_cnt   = 4'h0;
          nxt_st.word_idx  = 1'b0;
        end
      end
      SER_SHIFT: begin
        if (st_ff.div_cnt == st_ff.ctl[`CTL_SER_DIV]) begin
          nxt_st.div_cnt = 8'h00;
          nxt_st.ser_clk = ~st_ff.ser_clk;
          if (st_ff.ser_clk) begin
            nxt_st.ser_sync = 1'b0;
            if (st_ff.bit_cnt != `SER_LAST_BIT) begin
              nxt_st.bit_cnt = 4'(st_ff.bit_cnt + 4'h1);
              nxt_st.shift_a = {st_ff.shift_a[14:0], 1'b0};
              nxt_st.shift_b = {st_ff.shift_b[14:0], 1'b0};
            end else if (!st_ff.word_idx) begin
              nxt_st.word_idx = 1'b1;
              nxt_st.bit_cnt  = 4'h0;
              nxt_st.shift_a  = st_ff.next_a;
              nxt_st.shift_b  = st_ff.next_b;
              nxt_st.ser_sync = 1'b1;
            end else begin
              nxt_st.ser_state = SER_IDLE;
            end
          end
        end else begin
          nxt_st.div_cnt = 8'(st_ff.div_cnt + 8'h01);
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff                   <= '0;
      st_ff.wr_s1             <= 1'b1;
      st_ff.wr_s2             <= 1'b1;
      st_ff.wr_d              <= 1'b1;
      st_ff.rd_s1             <= 1'b1;
      st_ff.rd_s2             <= 1'b1;
      st_ff.rd_d              <= 1'b1;
      st_ff.oe_n_s1           <= 4'hf;
      st_ff.oe_n_s2           <= 4'hf;
      st_ff.ser_tri_s1        <= 1'b1;
      st_ff.ser_tri_s2        <= 1'b1;
      st_ff.ctl[`CTL_DIRECT_SEL]  <= `RST_DIRECT_SEL;
      st_ff.ctl[`CTL_SER_DIV]     <= `RST_SER_DIV;
      st_ff.ctl[`CTL_SER_ORDER_A] <= `RST_SER_ORDER_A;
      st_ff.ctl[`CTL_SER_ORDER_B] <= `RST_SER_ORDER_B;
      st_ff.ctl[`CTL_MODE]        <= `RST_MODE;
      st_ff.strobe_n          <= 1'b1;
      st_ff.was_empty         <= 1'b1;
      st_ff.irq_n             <= 1'b1;
      st_ff.ser_state         <= SER_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // byte lane enables, active while the matching pin is low
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign lane_oe[g] = ~st_ff.oe_n_s2[g];
  end

  assign parallel_port_a_out = {st_ff.port_a[15:8], st_ff.low_a};
  assign parallel_port_b_out = {st_ff.port_b[15:8], st_ff.low_b};
  assign parallel_port_a_oe  = {{8{lane_oe[3]}}, {8{lane_oe[2]}}};
  assign parallel_port_b_oe  = {{8{lane_oe[1]}}, {8{lane_oe[0]}}};
  assign new_sample_strobe_n = st_ff.strobe_n;
  assign buffer_ready_irq_n  = st_ff.irq_n;
  assign serial_out_a        = st_ff.shift_a[15];
  assign serial_out_b        = st_ff.shift_b[15];
  assign serial_bit_clock    = st_ff.ser_clk;
  assign serial_frame_strobe = st_ff.ser_sync;
  assign serial_oe           = ~st_ff.ser_tri_s2;
  assign host_data_out       = st_ff.rd_data;
  assign host_data_oe        = st_ff.rd_active;

endmodule // downconverter_output_host_port

// *** testbench/ddc_out_props.sv ***
// assertions on the pins of the downconverter output port
`timescale 1ns/1ps
module ddc_out_props (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // watched pins
  input wire logic [15:0] parallel_port_a_out,
  input wire logic [15:0] parallel_port_a_oe,
  input wire logic [15:0] parallel_port_b_out,
  input wire logic [15:0] parallel_port_b_oe,
  input wire logic        port_a_high_byte_oe_n,
  input wire logic        port_a_low_byte_oe_n,
  input wire logic        port_b_high_byte_oe_n,
  input wire logic        port_b_low_byte_oe_n,
  input wire logic        new_sample_strobe_n,
  input wire logic        buffer_ready_irq_n,
  input wire logic        serial_bit_clock,
  input wire logic        serial_frame_strobe,
  input wire logic        serial_oe,
  input wire logic        serial_tristate_ctl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // four samples cover the two-flop pin synchronizer
  property p_strobe; $fell(new_sample_strobe_n) |=> new_sample_strobe_n; endproperty
  property p_irq; $fell(buffer_ready_irq_n) |-> !buffer_ready_irq_n [*8] ##1 buffer_ready_irq_n;
  endproperty
  property p_ah; port_a_high_byte_oe_n [*4] |=> parallel_port_a_oe[15:8] == 8'h00; endproperty
  property p_al; !port_a_low_byte_oe_n [*4] |=> parallel_port_a_oe[7:0] == 8'hff; endproperty
  property p_bh; port_b_high_byte_oe_n [*4] |=> parallel_port_b_oe[15:8] == 8'h00; endproperty
  property p_bl; port_b_low_byte_oe_n [*4] |=> parallel_port_b_oe[7:0] == 8'h00; endproperty
  property p_tri; serial_tristate_ctl [*4] |=> !serial_oe; endproperty
  property p_hold;
    new_sample_strobe_n |-> $stable(parallel_port_a_out[15:8]) && $stable(parallel_port_b_out[15:8]);
  endproperty
  property p_frame; $rose(serial_frame_strobe) |-> !serial_bit_clock; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe low too long");
  a_irq: assert property (p_irq) else $error("interrupt width wrong");
  a_ah: assert property (p_ah) else $error("a high byte driven");
  a_al: assert property (p_al) else $error("a low byte floating");
  a_bh: assert property (p_bh) else $error("b high byte driven");
  a_bl: assert property (p_bl) else $error("b low byte driven");
  a_tri: assert property (p_tri) else $error("serial pins driven");
  a_hold: assert property (p_hold) else $error("direct value moved");
  a_frame: assert property (p_frame) else $error("frame strobe off clock");
  c_strobe: cover property ($fell(new_sample_strobe_n));
  c_irq: cover property ($fell(buffer_ready_irq_n));
  c_frame: cover property ($rose(serial_frame_strobe));
endmodule // ddc_out_props

bind downconverter_output_host_port ddc_out_props u_props (
  .core_clk(core_clk), .rst(rst),
  .parallel_port_a_out(parallel_port_a_out), .parallel_port_a_oe(parallel_port_a_oe),
  .parallel_port_b_out(parallel_port_b_out), .parallel_port_b_oe(parallel_port_b_oe),
  .port_a_high_byte_oe_n(port_a_high_byte_oe_n), .port_a_low_byte_oe_n(port_a_low_byte_oe_n),
  .port_b_high_byte_oe_n(port_b_high_byte_oe_n), .port_b_low_byte_oe_n(port_b_low_byte_oe_n),
  .new_sample_strobe_n(new_sample_strobe_n), .buffer_ready_irq_n(buffer_ready_irq_n),
  .serial_bit_clock(serial_bit_clock), .serial_frame_strobe(serial_frame_strobe),
  .serial_oe(serial_oe), .serial_tristate_ctl(serial_tristate_ctl)
);

// *** testbench/host_model.sv ***
// processor-side model driving the write and read strobes
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic       core_clk,
  // strobes and buses
  output logic            host_write_strobe,
  output logic            host_read_strobe,
  output logic [2:0]      host_addr_bus,
  output logic [7:0]      host_data_in,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe
);
  initial begin
    host_write_strobe = 1'b1;
    host_read_strobe = 1'b1;
    host_addr_bus = 3'h0;
    host_data_in = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // buses held five cycles around each edge, beyond the synchronizer
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host_addr_bus = a;
    host_data_in = d;
    hold(5);
    host_write_strobe = 1'b0;
    hold(5);
    host_write_strobe = 1'b1;
    hold(5);
    host_data_in = ~d; // released bus shows no stale byte
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    host_addr_bus = a;
    hold(5);
    host_read_strobe = 1'b0;
    hold(6);
    d = host_data_oe ? host_data_out : 8'hxx;
    host_read_strobe = 1'b1;
    hold(6);
  endtask
endmodule // host_model

// *** testbench/test_downconverter_output_host_port.sv ***
// self-checking bench of the downconverter output port
`timescale 1ns/1ps
module test_downconverter_output_host_port
  import ddc_out_pkg::*;
;
  logic core_clk = 0, rst = 1, sample_valid = 0, ser_tri = 0;
  logic sample_ready, strobe_n, irq_n, so_a, so_b, bclk, fstb, serial_oe;
  logic wr_s, rd_s, d_oe;
  logic [2:0] addr, item_sel = 0, sel_cfg = 0;
  logic [3:0] oe_n = 0;
  logic [7:0] d_in, d_out, d;
  logic [15:0] pa, pb, pa_oe, pb_oe, wa, wb;
  sample_s sample_data = '0, s0, q[$];
  int n_errors = 0, checked = 0, low_n = 0;

  always #10 core_clk = ~core_clk;

  downconverter_output_host_port DUT (
    .core_clk(core_clk), .rst(rst), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data),
    .parallel_port_a_out(pa), .parallel_port_a_oe(pa_oe),
    .parallel_port_b_out(pb), .parallel_port_b_oe(pb_oe),
    .port_a_high_byte_oe_n(oe_n[3]), .port_a_low_byte_oe_n(oe_n[2]),
    .port_b_high_byte_oe_n(oe_n[1]), .port_b_low_byte_oe_n(oe_n[0]),
    .new_sample_strobe_n(strobe_n), .buffer_item_select(item_sel),
    .buffer_ready_irq_n(irq_n), .serial_out_a(so_a), .serial_out_b(so_b),
    .serial_bit_clock(bclk), .serial_frame_strobe(fstb), .serial_oe(serial_oe),
    .serial_tristate_ctl(ser_tri), .host_write_strobe(wr_s), .host_read_strobe(rd_s),
    .host_addr_bus(addr), .host_data_in(d_in), .host_data_out(d_out), .host_data_oe(d_oe)
  );
  host_model host (
    .core_clk(core_clk), .host_write_strobe(wr_s), .host_read_strobe(rd_s),
    .host_addr_bus(addr), .host_data_in(d_in), .host_data_out(d_out), .host_data_oe(d_oe)
  );

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  function automatic sample_s rnd();
    logic [127:0] r;
    r = {$urandom, $urandom, $urandom, $urandom};
    return r[111:0];
  endfunction
  function automatic logic [15:0] item(input sample_s s, input logic [2:0] c);
    case (c)
      3'h0: return s.i;
      3'h1: return s.q;
      3'h2: return s.mag;
      3'h3: return s.phase;
      3'h4: return s.freq;
      default: return 16'h0000;
    endcase
  endfunction
  function automatic logic [15:0] dir_hi(input sample_s s, input logic [2:0] c);
    case (c)
      3'h1: return {s.mag[15:8], s.phase[15:8]};
      3'h2: return {s.freq[15:8], s.mag[15:8]};
      default: return {s.i[15:8], s.q[15:8]};
    endcase
  endfunction
  // valid stays up between calls so back-to-back words need no gap
  task send(input sample_s s);
    sample_data = s;
    sample_valid = 1'b1;
    #1;
    while (sample_ready !== 1'b1) step(1);
    @(posedge core_clk);
    q.push_back(s);
    #2;
  endtask
  task ser_word;
    while (fstb !== 1'b1) step(1);
    for (int k = 0; k < 16; k++) begin
      while (bclk !== 1'b0) step(1);
      while (bclk !== 1'b1) step(1);
      wa = {wa[14:0], so_a};
      wb = {wb[14:0], so_b};
    end
  endtask
  task final_report;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (!rst && strobe_n === 1'b0 && q.size() != 0)
      chk({pa[15:8], pb[15:8]}, dir_hi(q.pop_front(), sel_cfg));
    if (!rst && irq_n === 1'b0) low_n++;
    else if (low_n != 0) begin
      chk(16'(low_n), 16'h0008);
      low_n = 0;
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    final_report;
  end

  initial begin
    void'($urandom(65126));
    step(5);
    rst = 0;
    chk({12'h000, strobe_n, irq_n, serial_oe, d_oe}, 16'h000c);
    $display("test reset done");
    s0 = rnd();
    send(s0);
    sample_valid = 1'b0;
    ser_word;
    chk(wa, s0.i);
    chk(wb, s0.mag);
    $display("test serial done");
    for (int c = 0; c < 8; c++) begin
      item_sel = 3'(c);
      step(6);
      chk({pa[7:0], pb[7:0]}, item(s0, 3'(c)));
    end
    $display("test item select done");
    host.rd(3'h0, d);
    chk({8'h00, d}, 16'h0001);
    host.rd(3'h7, d);
    chk({8'h00, d}, 16'h001a);
    host.wr(3'h0, 8'h01);
    host.rd(3'h4, d);
    chk({8'h00, d}, 16'h0001);
    sel_cfg = 3'h1;
    host.wr(3'h4, 8'h05);
    host.rd(3'h2, d);
    host.rd(3'h0, d);
    chk({8'h00, d}, 16'h0000);
    $display("test host port done");
    // more than seven sets forces the store to drop; an idle cycle
    // between words keeps every strobe a pulse of its own
    repeat (20) begin
      send(rnd());
      sample_valid = 1'b0;
      step(1);
    end
    step(10);
    chk(16'(q.size()), 16'h0000);
    host.rd(3'h1, d);
    chk({8'h00, d}, 16'h0007);
    host.rd(3'h0, d);
    chk({8'h00, d}, 16'h0007);
    // third direct source: freq on a, mag on b
    host.wr(3'h0, 8'h02);
    sel_cfg = 3'h2;
    send(rnd());
    sample_valid = 1'b0;
    step(5);
    chk(16'(q.size()), 16'h0000);
    $display("test stream done");
    repeat (8) begin
      oe_n = 4'($urandom);
      ser_tri = 1'($urandom);
      step(5);
      chk(pa_oe, {{8{~oe_n[3]}}, {8{~oe_n[2]}}});
      chk(pb_oe, {{8{~oe_n[1]}}, {8{~oe_n[0]}}});
      chk({15'h0000, serial_oe}, {15'h0000, ~ser_tri});
    end
    $display("test enables done");
    final_report;
  end
endmodule // test_downconverter_output_host_port
